// file: hdl/bus_front_end_pkg.sv
// package of constants shared by both ends of the bus front end
// assumes one system clock, synchronous active-low reset
//
// What this block does
// - capture address, data, status while running
// - register byte-cycle and upper-byte indicators too
// - host-written 8-bit control word sets modes
// - control bit 6 picks strobe trigger source
// - 16-bit: upper data; 8-bit: status to analyzer
// - indicators steer the low byte multiplexer
// - load mode drives bus from host values
// - latch host address low byte on writes
// - six 256x1 pattern memories, byte addressed
// - inverted memory outputs combine into pattern-true
// - break strobe clocks pattern latch, drives break
// - delayed analyzer clock and strobe from trigger
// - stimulus pulse sets stimulus break latch
// - qualify pulse latches inverted halt level as qualifier
// - qualified halt rise sets halt break latch
// - halt break clears qualifier, needs requalify
// - host enables breaks per configuration; break-set write sets stimulus latch regardless
// - host resets break right after detection
// - decode host writes into seven strobes
// - low status byte readable, active-low form
// - upper status: pattern data, stimulus, byte
// - analyzer reads preprocessor then emulator identifier
package bus_front_end_pkg;
    // ------------------------------------------------------------
    // host write/read register offsets (word addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_BREAK_RESET = 4'h0;
    localparam logic [3:0] OFS_PATTERN_LOAD = 4'h1;
    localparam logic [3:0] OFS_CONTROL = 4'h2;
    localparam logic [3:0] OFS_EMU_ID = 4'h3;
    localparam logic [3:0] OFS_BREAK_SET = 4'h4;
    localparam logic [3:0] OFS_SELF_TEST = 4'h5;
    localparam logic [3:0] OFS_ADDR_LATCH = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h7;
    localparam logic [3:0] OFS_IDS = 4'h8;
    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CW_RUN = 0;
    localparam int CW_WIDE = 1;
    localparam int CW_PAT_EN = 2;
    localparam int CW_STIM_EN = 3;
    localparam int CW_HALT_EN = 4;
    localparam int CW_DRIVE_EN = 5;
    localparam int CW_TRIG_SEL = 6;
    localparam logic [7:0] CW_RESET = 8'h00;
    // ------------------------------------------------------------
    // status fields (true-high inside, inverted on the low byte)
    // ------------------------------------------------------------
    localparam int ST_PAT = 0;
    localparam int ST_STIM = 1;
    localparam int ST_HALT = 2;
    localparam int ST_QUAL = 3;
    localparam int ST_BREAK = 4;
    localparam int ST_RUN = 5;
    localparam int ST_UPPER = 6;
    // ------------------------------------------------------------
    // field widths and timing
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int STAT_W = 8;
    localparam int N_PAT = 6;
    localparam int CLK_MHZ = 250;
    localparam int STROBE_DELAY_NS = 20;
    localparam int STROBE_DELAY_CYC = (STROBE_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] PREPROC_ID = 8'h5A; // arbitrary value
endpackage : bus_front_end_pkg

// file: hdl/bus_front_end_if.sv
// interface joining the front end to its host-side controller
// assumes both ends share i_sys_clk
interface bus_front_end_if;
    logic [3:0] wr_addr;
    logic [7:0] wr_data;
    logic wr_stb;
    logic [3:0] rd_addr;
    logic [15:0] rd_data;
    modport device (input wr_addr, input wr_data, input wr_stb, input rd_addr,
        output rd_data);
    modport host (output wr_addr, output wr_data, output wr_stb, output rd_addr,
        input rd_data);
endinterface : bus_front_end_if

// file: hdl/bus_front_end.sv
// emulation bus front end: capture, format, pattern match, breaks
// assumes pins and analyzer lines are asynchronous and synchronised here
module bus_front_end
    import bus_front_end_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    bus_front_end_if.device host,
    input wire logic i_analysis_clock_n,
    input wire logic [ADDR_W-1:0] i_emu_addr,
    input wire logic [DATA_W-1:0] i_emu_data,
    input wire logic [STAT_W-1:0] i_emu_status,
    input wire logic i_byte_cycle_n,
    input wire logic i_upper_byte_n,
    input wire logic i_analyzer_stimulus,
    input wire logic i_analyzer_halt,
    input wire logic i_halt_qualify_clk_n,
    output logic [ADDR_W+DATA_W-1:0] o_analyzer_output_bus,
    output logic o_analyzer_clock,
    output logic o_break_strobe,
    output logic o_emu_break_n
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [4:0] sync1_reg;
    logic [4:0] sync2_reg;
    logic [4:0] sync_prev_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sync1_reg <= 5'h1F;
            sync2_reg <= 5'h1F;
            sync_prev_reg <= 5'h1F;
        end else if (i_clk_en) begin
            sync1_reg <= {i_analysis_clock_n, i_analyzer_stimulus, i_analyzer_halt,
                i_halt_qualify_clk_n, 1'b1};
            sync2_reg <= sync1_reg;
            sync_prev_reg <= sync2_reg;
        end
    end
    wire logic anal_fall = sync_prev_reg[4] & ~sync2_reg[4];
    wire logic stim_rise = ~sync_prev_reg[3] & sync2_reg[3];
    wire logic halt_rise = ~sync_prev_reg[2] & sync2_reg[2];
    wire logic qual_fall = sync_prev_reg[1] & ~sync2_reg[1];
    wire logic halt_level = sync2_reg[2];
    // bus pins pass two flops; sampled on the synchronised clock edge
    logic [ADDR_W+DATA_W+STAT_W+1:0] pin1_reg;
    logic [ADDR_W+DATA_W+STAT_W+1:0] pin2_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pin1_reg <= '0;
            pin2_reg <= '0;
        end else if (i_clk_en) begin
            pin1_reg <= {i_emu_addr, i_emu_data, i_emu_status, i_byte_cycle_n, i_upper_byte_n};
            pin2_reg <= pin1_reg;
        end
    end
    // ------------------------------------------------------------
    // host write decode and control registers
    // ------------------------------------------------------------
    logic [7:0] control_word_bits_reg;
    logic [7:0] emu_id_reg;
    logic [7:0] addr_latch_reg;
    wire logic wr_break_reset = host.wr_stb && host.wr_addr == OFS_BREAK_RESET;
    wire logic wr_pattern = host.wr_stb && host.wr_addr == OFS_PATTERN_LOAD;
    wire logic wr_break_set = host.wr_stb && host.wr_addr == OFS_BREAK_SET;
    wire logic wr_self_test = host.wr_stb && host.wr_addr == OFS_SELF_TEST;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            control_word_bits_reg <= CW_RESET;
            emu_id_reg <= 8'h00;
            addr_latch_reg <= 8'h00;
        end else if (i_clk_en && host.wr_stb) begin
            if (host.wr_addr == OFS_CONTROL) begin
                control_word_bits_reg <= host.wr_data;
            end
            if (host.wr_addr == OFS_EMU_ID) begin
                emu_id_reg <= host.wr_data;
            end
            if (host.wr_addr == OFS_ADDR_LATCH) begin
                addr_latch_reg <= host.wr_data;
            end
        end
    end
    wire logic run_mode = control_word_bits_reg[CW_RUN];
    // ------------------------------------------------------------
    // capture latches
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] captured_addr;
    logic [DATA_W-1:0] captured_data;
    logic [STAT_W-1:0] captured_status;
    logic byte_cycle_n_reg;
    logic upper_byte_n_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            captured_addr <= '0;
            captured_data <= '0;
            captured_status <= '0;
            byte_cycle_n_reg <= 1'b1;
            upper_byte_n_reg <= 1'b1;
        end else if (i_clk_en) begin
            if (run_mode && anal_fall) begin
                {captured_addr, captured_data, captured_status} <=
                    pin2_reg[ADDR_W+DATA_W+STAT_W+1:2];
                byte_cycle_n_reg <= pin2_reg[1];
                upper_byte_n_reg <= pin2_reg[0];
            end else if (!run_mode) begin
                captured_addr <= {3{addr_latch_reg}};
                captured_data <= {2{addr_latch_reg}};
                captured_status <= addr_latch_reg;
            end
        end
    end
    // ------------------------------------------------------------
    // formatting: byte steering and data/status multiplex
    // ------------------------------------------------------------
    // byte steering
    wire logic send_upper = ~byte_cycle_n_reg & ~upper_byte_n_reg;
    wire logic [7:0] low_byte = send_upper ? captured_data[15:8] : captured_data[7:0];
    wire logic [7:0] high_chan = control_word_bits_reg[CW_WIDE] ?
        captured_data[15:8] : captured_status;
    // ------------------------------------------------------------
    // pattern memories
    // ------------------------------------------------------------
    // six 256x1 memories
    logic [255:0] pattern_mem [N_PAT];
    logic [N_PAT-1:0] pat_hit;
    logic [7:0] pat_byte [N_PAT];
    always_comb begin
        pat_byte[0] = captured_addr[7:0];
        pat_byte[1] = captured_addr[15:8];
        pat_byte[2] = captured_addr[23:16];
        pat_byte[3] = captured_data[7:0];
        pat_byte[4] = captured_data[15:8];
        pat_byte[5] = captured_status;
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && wr_pattern) begin
            for (int i = 0; i < N_PAT; i++) begin
                pattern_mem[i][pat_byte[i]] <= host.wr_data[i];
            end
        end
    end
    always_comb begin
        for (int i = 0; i < N_PAT; i++) begin
            pat_hit[i] = ~pattern_mem[i][pat_byte[i]];
        end
    end
    wire logic pattern_true = &pat_hit;
    // ------------------------------------------------------------
    // delayed strobe generator
    // ------------------------------------------------------------
    logic [7:0] delay_cnt_reg;
    wire logic trigger = control_word_bits_reg[CW_TRIG_SEL] ? wr_self_test : anal_fall;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            delay_cnt_reg <= 8'h00;
            o_analyzer_clock <= 1'b0;
            o_break_strobe <= 1'b0;
            o_analyzer_output_bus <= '0;
        end else if (i_clk_en) begin
            if (trigger) begin
                delay_cnt_reg <= 8'(STROBE_DELAY_CYC);
            end else if (delay_cnt_reg != 8'h00) begin
                delay_cnt_reg <= delay_cnt_reg - 8'h01;
            end
            o_analyzer_clock <= delay_cnt_reg == 8'h01;
            o_break_strobe <= delay_cnt_reg == 8'h01;
            o_analyzer_output_bus <= {captured_addr, high_chan, low_byte};
        end
    end
    // ------------------------------------------------------------
    // break latches
    // ------------------------------------------------------------
    logic pat_brk_reg;
    logic stim_brk_reg;
    logic halt_brk_reg;
    logic qual_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            pat_brk_reg <= 1'b0;
            stim_brk_reg <= 1'b0;
            halt_brk_reg <= 1'b0;
            qual_reg <= 1'b0;
            o_emu_break_n <= 1'b1;
        end else if (i_clk_en) begin
            // pattern break on strobe; set wins over reset
            if (o_break_strobe && pattern_true && control_word_bits_reg[CW_PAT_EN]) begin
                pat_brk_reg <= 1'b1;
            end else if (wr_break_reset) begin
                pat_brk_reg <= 1'b0;
            end
            if ((stim_rise && control_word_bits_reg[CW_STIM_EN]) || wr_break_set) begin
                stim_brk_reg <= 1'b1;
            end else if (wr_break_reset) begin
                stim_brk_reg <= 1'b0;
            end
            if (halt_rise && qual_reg && control_word_bits_reg[CW_HALT_EN]) begin
                halt_brk_reg <= 1'b1;
            end else if (wr_break_reset) begin
                halt_brk_reg <= 1'b0;
            end
            if (halt_brk_reg) begin
                qual_reg <= 1'b0;
            end else if (qual_fall) begin
                qual_reg <= ~halt_level;
            end
            o_emu_break_n <= ~(control_word_bits_reg[CW_DRIVE_EN] &
                (pat_brk_reg | stim_brk_reg | halt_brk_reg));
        end
    end
    // ------------------------------------------------------------
    // host readback
    // ------------------------------------------------------------
    wire logic [7:0] status_hi = {1'b0, send_upper, run_mode, ~o_emu_break_n,
        qual_reg, halt_brk_reg, stim_brk_reg, pattern_true};
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            host.rd_data <= 16'h0000;
        end else if (i_clk_en) begin
            unique case (host.rd_addr)
                OFS_STATUS: host.rd_data <= {status_hi, ~status_hi};
                OFS_IDS: host.rd_data <= {emu_id_reg, PREPROC_ID};
                OFS_CONTROL: host.rd_data <= {8'h00, control_word_bits_reg};
                default: host.rd_data <= 16'h0000;
            endcase
        end
    end
endmodule : bus_front_end

// file: hdl/front_end_controller.sv
// host controller: Avalon-MM slave turned into front-end writes/reads
// assumes the device end on the same clock
module front_end_controller
    import bus_front_end_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    bus_front_end_if.host dev
);
    // ------------------------------------------------------------
    // one write strobe per accepted write; answer three edges after the take
    // ------------------------------------------------------------
    logic busy_reg;
    logic done_reg;
    logic stage_reg;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            stage_reg <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            dev.wr_stb <= 1'b0;
            dev.wr_addr <= 4'h0;
            dev.wr_data <= 8'h00;
            dev.rd_addr <= 4'h0;
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_clk_en) begin
            dev.wr_stb <= 1'b0;
            done_reg <= 1'b0;
            stage_reg <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            if (!busy_reg && !done_reg && (i_avs_read || i_avs_write)) begin
                busy_reg <= 1'b1;
                stage_reg <= 1'b1;
                dev.rd_addr <= i_avs_address;
                if (i_avs_write) begin
                    dev.wr_stb <= 1'b1;
                    dev.wr_addr <= i_avs_address;
                    dev.wr_data <= i_avs_writedata[7:0];
                end
            end else if (busy_reg && !stage_reg) begin
                // read data registered one edge after the address changed
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
                o_avs_waitrequest <= 1'b0;
                o_avs_readdata <= {16'h0000, dev.rd_data};
            end
        end
    end
endmodule : front_end_controller

// file: bench/bus_front_end_monitor.sv
// checker of the link between both ends and of the controller's Avalon side
// assumes one clock and a synchronous active-low reset
module bus_front_end_monitor
    import bus_front_end_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic [3:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // shadows of host-written values and of a break seen on status reads
    // ----------------------------------------
    logic [7:0] emu_reg;
    logic emu_known_reg;
    logic run_reg;
    logic brk_seen_reg;
    logic st_rd;
    assign st_rd = i_avs_read && !o_avs_waitrequest && i_avs_address == OFS_STATUS;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            emu_known_reg <= 1'b0;
        end else if (wr_stb && wr_addr == OFS_EMU_ID) begin
            emu_known_reg <= 1'b1;
            emu_reg <= wr_data;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            run_reg <= CW_RESET[CW_RUN];
        end else if (wr_stb && wr_addr == OFS_CONTROL) begin
            run_reg <= wr_data[CW_RUN];
        end
    end
    // a break seen on a status read stays until a break reset or a new control word
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n || (wr_stb && (wr_addr == OFS_BREAK_RESET || wr_addr == OFS_CONTROL))) begin
            brk_seen_reg <= 1'b0;
        end else if (st_rd && o_avs_readdata[8+ST_BREAK]) begin
            brk_seen_reg <= 1'b1;
        end
    end
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_wr_fwd;
        $rose(i_avs_write) |-> ##[1:2] wr_stb;
    endproperty
    a_wr_fwd: assert property (p_wr_fwd) else $error("write gave no strobe");
    property p_stb_fields;
        wr_stb |-> i_avs_write && wr_addr == i_avs_address && wr_data == i_avs_writedata[7:0];
    endproperty
    a_stb_fields: assert property (p_stb_fields) else $error("strobe fields wrong");
    property p_answer;
        $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest ##1 o_avs_waitrequest
            ##1 o_avs_waitrequest ##1 !o_avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not in cycle 3");
    property p_ids;
        $rose(i_avs_read) && i_avs_address == OFS_IDS |-> ##3 o_avs_readdata[7:0] == PREPROC_ID;
    endproperty
    a_ids: assert property (p_ids) else $error("front end id wrong");
    property p_emu;
        $rose(i_avs_read) && i_avs_address == OFS_IDS && emu_known_reg
            |-> ##3 o_avs_readdata[15:8] == emu_reg;
    endproperty
    a_emu: assert property (p_emu) else $error("emulator id wrong");
    property p_refused;
        $rose(i_avs_read) && i_avs_address > OFS_IDS |-> ##3 o_avs_readdata == 32'h0;
    endproperty
    a_refused: assert property (p_refused) else $error("unmapped read not zero");
    property p_run;
        $rose(i_avs_read) && i_avs_address == OFS_STATUS |-> ##3 o_avs_readdata[8+ST_RUN]
            == run_reg && o_avs_readdata[ST_RUN] != run_reg;
    endproperty
    a_run: assert property (p_run) else $error("run status wrong");
    property p_brk_hold;
        $rose(i_avs_read) && i_avs_address == OFS_STATUS && brk_seen_reg
            |-> ##3 o_avs_readdata[8+ST_BREAK];
    endproperty
    a_brk_hold: assert property (p_brk_hold) else $error("break dropped early");
    c_brk: cover property (st_rd && o_avs_readdata[8+ST_BREAK]);
    c_halt: cover property (st_rd && o_avs_readdata[8+ST_HALT]);
    c_reset: cover property (wr_stb && wr_addr == OFS_BREAK_RESET);
endmodule : bus_front_end_monitor

// file: bench/emulation_bus_preprocessor_tb.sv
// self-checking bench: controller and front end joined by their link
// assumes a 250 MHz system clock and the package constants
module emulation_bus_preprocessor_tb
    import bus_front_end_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd_q = 1'b0;
    logic wr_q = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd;
    logic wt, oclk, ostb, brk_n;
    logic ana_n = 1'b1;
    logic [23:0] ea = 24'h0;
    logic [15:0] ed = 16'h0;
    logic [7:0] es = 8'h0;
    logic bc_n = 1'b1;
    logic ub_n = 1'b1;
    logic stim = 1'b0;
    logic halt = 1'b0;
    logic qual_n = 1'b1;
    logic [39:0] obus;
    logic [7:0] emu;
    int err_count = 0;
    int total_checks = 0;
    int n;
    bus_front_end_if link();
    bus_front_end i_bus_front_end (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(1'b1),
        .host(link.device), .i_analysis_clock_n(ana_n), .i_emu_addr(ea), .i_emu_data(ed),
        .i_emu_status(es), .i_byte_cycle_n(bc_n), .i_upper_byte_n(ub_n),
        .i_analyzer_stimulus(stim), .i_analyzer_halt(halt), .i_halt_qualify_clk_n(qual_n),
        .o_analyzer_output_bus(obus), .o_analyzer_clock(oclk), .o_break_strobe(ostb),
        .o_emu_break_n(brk_n));
    front_end_controller i_front_end_controller (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_clk_en(1'b1), .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q),
        .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .dev(link.host));
    bus_front_end_monitor i_bus_front_end_monitor (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q), .i_avs_writedata(wdat),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wt), .wr_addr(link.wr_addr),
        .wr_data(link.wr_data), .wr_stb(link.wr_stb));
    initial begin
        forever #2 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string s);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s: %h vs %h", $time, s, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    task automatic tmo(input string s);
        err_count++;
        $display("CHECK FAILED %0t timeout %s", $time, s);
        results();
    endtask : tmo
    task automatic tick(input int k);
        repeat (k) @(posedge i_sys_clk);
    endtask : tick
    // one Avalon access: held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        adr <= a;
        wdat <= {24'h0, d};
        wr_q <= w;
        rd_q <= !w;
        for (n = 0; n < 20; n++) begin
            @(posedge i_sys_clk);
            if (wt === 1'b0) break;
        end
        rd = rdat;
        if (n == 20) tmo("bus");
        wr_q <= 1'b0;
        rd_q <= 1'b0;
        @(posedge i_sys_clk);
    endtask : acc
    initial begin
        logic [7:0] a;
        logic p;
        void'($urandom(32'h0D307D66));
        tick(6);
        i_rst_n <= 1'b1;
        tick(1);
        chk(40'(brk_n), 40'h1, "idle break");
        emu = 8'($urandom);
        acc(1'b1, OFS_EMU_ID, emu);
        acc(1'b0, OFS_IDS, 8'h00);
        chk(40'(rd), {24'h0, emu, PREPROC_ID}, "ids");
        for (int k = 9; k < 16; k++) begin
            acc(1'b0, 4'(k), 8'h00);
            chk(40'(rd), 40'h0, "unmapped");
        end
        repeat (3) begin
            a = 8'($urandom) & 8'h43;
            acc(1'b1, OFS_CONTROL, a);
            acc(1'b0, OFS_STATUS, 8'h00);
            chk(40'({rd[8+ST_RUN], rd[ST_RUN], rd[ST_BREAK]}),
                40'({a[CW_RUN], ~a[CW_RUN], 1'b1}), "status");
            acc(1'b0, OFS_CONTROL, 8'h00);
            chk(40'(rd), 40'(a), "control");
        end
        for (int w = 0; w < 4; w++) begin
            acc(1'b1, OFS_CONTROL, {6'h0, w[0], 1'b1});
            ea <= 24'($urandom);
            ed <= 16'($urandom);
            es <= 8'($urandom);
            bc_n <= !w[1];
            ub_n <= !w[1];
            tick(3);
            ana_n <= 1'b0;
            for (n = 0; n < 40; n++) begin
                @(negedge i_sys_clk);
                if (oclk === 1'b1) break;
            end
            if (n == 40) tmo("capture");
            chk(40'(n > STROBE_DELAY_CYC), 40'h1, "delay");
            chk(40'(ostb), 40'h1, "strobe");
            chk(obus, {ea, w[0] ? ed[15:8] : es, w[1] ? ed[15:8] : ed[7:0]},
                "format");
            tick(1);
            ana_n <= 1'b1;
            bc_n <= 1'b1;
            ub_n <= 1'b1;
        end
        // stimulus break, line driven only when enabled
        for (int d = 0; d < 2; d++) begin
            acc(1'b1, OFS_CONTROL, {2'b00, d[0], 5'h09});
            stim <= 1'b1;
            tick(1);
            stim <= 1'b0;
            tick(8);
            chk(40'(brk_n), 40'(!d[0]), "stim break");
            acc(1'b0, OFS_STATUS, 8'h00);
            chk(40'(rd[8+ST_STIM]), 40'h1, "stim status");
            acc(1'b1, OFS_BREAK_RESET, 8'h00);
            tick(2);
            chk(40'(brk_n), 40'h1, "cleared");
        end
        acc(1'b1, OFS_BREAK_SET, 8'h00);
        tick(4);
        chk(40'(brk_n), 40'h0, "break set");
        acc(1'b1, OFS_BREAK_RESET, 8'h00);
        acc(1'b1, OFS_CONTROL, 8'h31);
        qual_n <= 1'b0;
        tick(1);
        qual_n <= 1'b1;
        tick(4);
        acc(1'b0, OFS_STATUS, 8'h00);
        chk(40'(rd[8+ST_QUAL]), 40'h1, "qualified");
        for (int h = 0; h < 2; h++) begin
            halt <= 1'b1;
            tick(8);
            chk(40'(brk_n), 40'(h), "halt break");
            repeat (2) acc(1'b0, OFS_STATUS, 8'h00);
            chk(40'({rd[8+ST_HALT], rd[8+ST_QUAL]}), 40'({!h[0], 1'b0}), "halt");
            acc(1'b1, OFS_BREAK_RESET, 8'h00);
            halt <= 1'b0;
            tick(4);
        end
        // pattern load through the address latch in load mode
        a = 8'($urandom);
        acc(1'b1, OFS_CONTROL, 8'h00);
        acc(1'b1, OFS_ADDR_LATCH, a);
        acc(1'b1, OFS_PATTERN_LOAD, 8'h3F);
        acc(1'b1, OFS_ADDR_LATCH, ~a);
        acc(1'b1, OFS_PATTERN_LOAD, 8'h00);
        acc(1'b0, OFS_STATUS, 8'h00);
        p = rd[8+ST_PAT];
        acc(1'b1, OFS_ADDR_LATCH, a);
        acc(1'b0, OFS_STATUS, 8'h00);
        chk(40'(rd[8+ST_PAT] ^ p), 40'h1, "pattern");
        if (p) begin
            acc(1'b1, OFS_ADDR_LATCH, ~a);
        end
        acc(1'b1, OFS_CONTROL, 8'h64);
        acc(1'b1, OFS_SELF_TEST, 8'h00);
        tick(12);
        chk(40'(brk_n), 40'h0, "pattern break");
        results();
    end
endmodule : emulation_bus_preprocessor_tb
